// *** gex_top.sv ***
// Purpose: spi gpio expander register block with pin control and interrupt
// Assumes: spi mode 0 (sample rising, shift falling), link sampled by sys_clk_in
// Notes: pin rails and pull-ups are pad-side; this block drives enables only
// Behaviour
// (RULE1) all eight pins become inputs after power-up and every reset
// (RULE2) serial port is clock, chip select, data in, data out only
// (RULE3) master asserts chip select before clocking; frames only while selected
// (RULE4) master keeps serial clock at or below 26 MHz; this block needs each sclk level to last over one 50 MHz sys_clk_in period
// (RULE5) command byte arrives msb first, read/write flag first
// (RULE6) command bit 7 one means read, zero means write
// (RULE7) bits 6:1 select the register; bit 0 is ignored
// (RULE8) master returns serial clock low after the last transfer
// (RULE9) eleven 8-bit registers decoded at selectors 0x00 to 0x0a
// (RULE10) pin state and interrupt status are read-only, others read/write
// (RULE11) reset loads 0xff into output, direction, filter; zero elsewhere
// (RULE12) selector is command bits 6:1, address shifted up one bit
// (RULE13) writes to read-only or unknown selectors ignored; unknown reads zero
// (RULE14) direction bit zero makes an output, one an input; msb is pin 7
// (RULE15) pin state reads inputs (maybe inverted) and output values; read clears interrupt
// (RULE16) low pulse over 40 ns on hardware reset restores defaults
// (RULE17) interrupt pulls its open-drain line low while pending
`timescale 1ns/100ps
module gex_top #(
  parameter int FILT_CYC = gex_pkg::FILT_CYC  // input filter length in clocks
) (
  input  wire logic       sys_clk_in,       // system clock, 50 MHz
  input  wire logic       rst_in,           // sync reset, active high
  input  wire logic       hw_reset_n_in,    // hardware reset pin, active low
  input  wire logic       spi_sclk_in,      // serial clock from master
  input  wire logic       spi_cs_n_in,      // chip select, active low
  input  wire logic       spi_sdi_in,       // serial data into device
  output logic            spi_sdo_out,      // serial data out of device
  output logic            spi_sdo_oe_out,   // sdo driven while selected
  input  wire logic [7:0] expander_pins_in, // pin levels
  output logic      [7:0] expander_pins_out, // pin drive values
  output logic      [7:0] expander_pins_oe_out, // pin drive enables
  output logic      [7:0] pullup_en_out,    // pad pull-up enables
  output logic            irq_n_out,        // open-drain data, always low
  output logic            irq_n_oe_out      // high pulls the irq line low
);
  localparam int FW = $clog2(FILT_CYC + 1);
  initial begin
    if (FILT_CYC < 1) $error("FILT_CYC must be at least 1");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_DONE} gex_ph_e;

  typedef struct packed {
    gex_ph_e     ph;
    logic        sclk_q;
    logic [2:0]  bitn;
    logic [7:0]  shin;
    logic [7:0]  shout;
    logic        rd;
    logic [5:0]  sel;
    logic [7:0]  out_lvl;
    logic [7:0]  pol;
    logic [7:0]  dir;
    logic [7:0]  pull;
    logic [7:0]  ien;
    logic [7:0]  hiz;
    logic [7:0]  ipend;
    logic [7:0]  rise;
    logic [7:0]  fall;
    logic [7:0]  filt;
    logic [7:0]  stable;
    logic [7:0]  ref_lvl;
    logic [7:0][FW-1:0] fcnt;
    logic [3:0]  rstn_cnt;
    logic        sdo;
  } gex_s;

  gex_s       st;
  gex_s       next_st;
  logic [2:0] s_link;
  logic [7:0] pin_s;
  logic       sclk_s;
  logic       cs_n_s;
  logic       cs_sel_s;
  logic       sdi_s;
  logic       hwr_n_s;

  // every asynchronous pin passes two flip-flops
  // active-low pins enter inverted so a cleared synchroniser reads as idle, not as select or reset
  gex_sync #(.W(3)) u_link_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   ({spi_sclk_in, spi_sdi_in, ~hw_reset_n_in}),
    .sync_out   (s_link)
  );
  gex_sync #(.W(1)) u_cs_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   (~spi_cs_n_in),
    .sync_out   (cs_sel_s)
  );
  gex_sync #(.W(8)) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .async_in   (expander_pins_in),
    .sync_out   (pin_s)
  );
  assign sclk_s  = s_link[2];
  assign sdi_s   = s_link[1];
  assign hwr_n_s = ~s_link[0];
  assign cs_n_s  = ~cs_sel_s;

  // next-state logic for link, registers, filter and interrupts
  always_comb begin
    logic [7:0] lvl_view;
    logic [7:0] rd_val;
    logic [7:0] rose;
    logic [7:0] fell;
    logic [7:0] hit;
    logic [7:0] byte_in;
    logic       rise_e;
    logic       fall_e;
    logic       gsr_rd;
    lvl_view = '0;
    rd_val   = '0;
    rose     = '0;
    fell     = '0;
    hit      = '0;
    byte_in  = '0;
    gsr_rd   = 1'b0;
    next_st  = st;
    next_st.sclk_q = sclk_s;
    rise_e = sclk_s & ~st.sclk_q;
    fall_e = ~sclk_s & st.sclk_q;

    // input filter: a change must hold FILT_CYC clocks when enabled
    for (int i = 0; i < gex_pkg::PIN_W; i++) begin
      if (!st.filt[i]) begin
        next_st.stable[i] = pin_s[i];
        next_st.fcnt[i]   = '0;
      end else if (pin_s[i] == st.stable[i]) begin
        next_st.fcnt[i] = '0;
      end else if (st.fcnt[i] == FW'(FILT_CYC - 1)) begin
        next_st.stable[i] = pin_s[i];
        next_st.fcnt[i]   = '0;
      end else begin
        next_st.fcnt[i] = st.fcnt[i] + FW'(1);
      end
    end

    // pin state view: input inverted where pol bit set, or last written output
    for (int i = 0; i < gex_pkg::PIN_W; i++) begin
      lvl_view[i] = st.dir[i] ? (st.stable[i] ^ st.pol[i]) : st.out_lvl[i]; // RULE15 RULE14
    end

    // read mux on the selector completing with this rise; unknown selectors read zero
    byte_in = {st.shin[6:0], sdi_s}; // RULE5
    unique case (byte_in[gex_pkg::CMD_SEL_HI:gex_pkg::CMD_SEL_LO])
      gex_pkg::A_LEVEL: rd_val = lvl_view;
      gex_pkg::A_OUT:   rd_val = st.out_lvl;
      gex_pkg::A_POL:   rd_val = st.pol;
      gex_pkg::A_DIR:   rd_val = st.dir;
      gex_pkg::A_PULL:  rd_val = st.pull;
      gex_pkg::A_IEN:   rd_val = st.ien;
      gex_pkg::A_HIZ:   rd_val = st.hiz;
      gex_pkg::A_IPEND: rd_val = st.ipend;
      gex_pkg::A_RISE:  rd_val = st.rise;
      gex_pkg::A_FALL:  rd_val = st.fall;
      gex_pkg::A_FILT:  rd_val = st.filt;
      default:          rd_val = '0; // RULE13 RULE9
    endcase

    // serial engine, mode 0, msb first
    unique case (st.ph)
      ST_IDLE: begin
        next_st.bitn = '0;
        if (!cs_n_s) begin
          next_st.ph = ST_CMD; // RULE3
        end
      end
      ST_CMD, ST_DATA: begin
        if (rise_e) begin
          next_st.shin = byte_in;
          next_st.bitn = st.bitn + 3'h1;
          if (st.bitn == gex_pkg::BIT_LAST) begin
            if (st.ph == ST_CMD) begin
              next_st.rd  = byte_in[gex_pkg::CMD_RW_BIT]; // RULE6
              next_st.sel = byte_in[gex_pkg::CMD_SEL_HI:gex_pkg::CMD_SEL_LO]; // RULE7 RULE12
              next_st.ph  = ST_DATA;
            end else begin
              next_st.ph = ST_DONE;
              if (!st.rd) begin
                unique case (st.sel)
                  gex_pkg::A_OUT:  next_st.out_lvl = byte_in;
                  gex_pkg::A_POL:  next_st.pol     = byte_in;
                  gex_pkg::A_DIR:  next_st.dir     = byte_in;
                  gex_pkg::A_PULL: next_st.pull    = byte_in;
                  gex_pkg::A_IEN:  next_st.ien     = byte_in;
                  gex_pkg::A_HIZ:  next_st.hiz     = byte_in;
                  gex_pkg::A_RISE: next_st.rise    = byte_in;
                  gex_pkg::A_FALL: next_st.fall    = byte_in;
                  gex_pkg::A_FILT: next_st.filt    = byte_in;
                  default: ; // RULE10 RULE13
                endcase
              end else if (st.sel == gex_pkg::A_LEVEL) begin
                gsr_rd = 1'b1;
              end
            end
          end
        end
        // load read data once the command is known, shift on falling edges
        if (st.ph == ST_CMD && next_st.ph == ST_DATA) begin
          next_st.shout = next_st.rd ? rd_val : '0;
        end else if (fall_e && st.ph == ST_DATA && st.bitn != '0) begin
          next_st.shout = {st.shout[6:0], 1'b0};
        end
        if (cs_n_s) begin
          next_st.ph = ST_IDLE; // RULE3
        end
      end
      ST_DONE: begin
        if (cs_n_s) begin
          next_st.ph = ST_IDLE; // RULE8
        end
      end
    endcase
    next_st.sdo = next_st.shout[7];

    // edge detect on filtered level; only inputs with enable raise a flag
    rose = next_st.stable & ~st.stable;
    fell = ~next_st.stable & st.stable;
    for (int i = 0; i < gex_pkg::PIN_W; i++) begin
      if (st.rise[i] | st.fall[i]) begin
        hit[i] = (rose[i] & st.rise[i]) | (fell[i] & st.fall[i]);
      end else begin
        hit[i] = rose[i] | fell[i];
      end
      hit[i] = hit[i] & st.dir[i] & st.ien[i];
    end
    // both-edge mode (rise and fall bits both zero) also clears when level returns to the last-read state
    for (int i = 0; i < gex_pkg::PIN_W; i++) begin
      if (!st.rise[i] && !st.fall[i] && next_st.stable[i] == st.ref_lvl[i]) begin
        next_st.ipend[i] = 1'b0;
      end
    end
    if (gsr_rd) begin
      next_st.ipend   = '0; // RULE15
      next_st.ref_lvl = next_st.stable;
    end
    next_st.ipend = next_st.ipend | hit; // set wins over clear

    // hardware reset pin: low longer than 40 ns restores defaults
    if (hwr_n_s) begin
      next_st.rstn_cnt = '0;
    end else if (st.rstn_cnt != 4'(gex_pkg::RSTN_CYC)) begin
      next_st.rstn_cnt = st.rstn_cnt + 4'h1;
    end
    if (st.rstn_cnt == 4'(gex_pkg::RSTN_CYC)) begin
      next_st.out_lvl = gex_pkg::RST_ONES; // RULE16 RULE11
      next_st.dir     = gex_pkg::RST_ONES; // RULE1
      next_st.filt    = gex_pkg::RST_ONES;
      next_st.pol     = gex_pkg::RST_ZERO;
      next_st.pull    = gex_pkg::RST_ZERO;
      next_st.ien     = gex_pkg::RST_ZERO;
      next_st.hiz     = gex_pkg::RST_ZERO;
      next_st.ipend   = gex_pkg::RST_ZERO;
      next_st.rise    = gex_pkg::RST_ZERO;
      next_st.fall    = gex_pkg::RST_ZERO;
    end
  end

  // state register with synchronous reset
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st         <= '0;
      st.ph      <= ST_IDLE;
      st.out_lvl <= gex_pkg::RST_ONES; // RULE11
      st.dir     <= gex_pkg::RST_ONES; // RULE1
      st.filt    <= gex_pkg::RST_ONES;
    end else begin
      st <= next_st;
    end
  end

  // pin drivers: output when direction bit is zero and not three-stated
  assign expander_pins_out    = st.out_lvl;
  assign expander_pins_oe_out = ~st.dir & ~st.hiz; // RULE14
  assign pullup_en_out        = st.pull & st.dir;
  assign spi_sdo_out          = st.sdo;
  assign spi_sdo_oe_out       = ~cs_n_s; // RULE2
  assign irq_n_out            = 1'b0;
  assign irq_n_oe_out         = |st.ipend; // RULE17
endmodule // gex_top

// *** gex_pkg.sv ***
// Purpose: shared constants for the spi gpio expander register block
// Assumes: eight pins, 8-bit registers, command byte msb first
// Notes: offsets are register selector values (command bits 6:1)
package gex_pkg;
  localparam int          PIN_W        = 8;
  localparam int          REG_CNT      = 11;
  localparam logic [5:0]  A_LEVEL      = 6'h00;
  localparam logic [5:0]  A_OUT        = 6'h01;
  localparam logic [5:0]  A_POL        = 6'h02;
  localparam logic [5:0]  A_DIR        = 6'h03;
  localparam logic [5:0]  A_PULL       = 6'h04;
  localparam logic [5:0]  A_IEN        = 6'h05;
  localparam logic [5:0]  A_HIZ        = 6'h06;
  localparam logic [5:0]  A_IPEND      = 6'h07;
  localparam logic [5:0]  A_RISE       = 6'h08;
  localparam logic [5:0]  A_FALL       = 6'h09;
  localparam logic [5:0]  A_FILT       = 6'h0a;
  localparam logic [7:0]  RST_ONES     = 8'hff;
  localparam logic [7:0]  RST_ZERO     = 8'h00;
  localparam int          CMD_RW_BIT   = 7;
  localparam int          CMD_SEL_HI   = 6;
  localparam int          CMD_SEL_LO   = 1;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam int          CLK_MHZ      = 50;
  localparam int          FILT_NS      = 1075;
  // filter must exceed the time, so round up
  localparam int          FILT_CYC     = (FILT_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int          RSTN_NS      = 40;
  localparam int          RSTN_CYC     = (RSTN_NS * CLK_MHZ + 999) / 1000;
endpackage

// *** gex_sync.sv ***
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to sys_clk_in
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module gex_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_in,  // system clock
  input  wire logic         rst_in,      // sync reset, active high
  input  wire logic [W-1:0] async_in,    // raw pins
  output logic      [W-1:0] sync_out     // synchronised pins
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gex_sync_s;
  gex_sync_s st;
  gex_sync_s next_st;

  // shift through two stages
  always_comb begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;
endmodule // gex_sync

// *** gex_top_props.sv ***
// Purpose: port checks for the expander block
// Assumes: one clock, sync reset active high
// Notes: link inputs reach the core two clocks late
`timescale 1ns/100ps
module gex_top_props #(
  parameter int FILT_CYC = gex_pkg::FILT_CYC  // filter length
) (
  input wire logic       sys_clk_in,           // clock
  input wire logic       rst_in,               // reset
  input wire logic       hw_reset_n_in,        // hw reset
  input wire logic       spi_sclk_in,          // link clock
  input wire logic       spi_cs_n_in,          // select
  input wire logic       spi_sdi_in,           // data in
  input wire logic       spi_sdo_out,          // data out
  input wire logic       spi_sdo_oe_out,       // data out enable
  input wire logic [7:0] expander_pins_in,     // pin levels
  input wire logic [7:0] expander_pins_out,    // pin drive
  input wire logic [7:0] expander_pins_oe_out, // pin enables
  input wire logic [7:0] pullup_en_out,        // pull-ups
  input wire logic       irq_n_out,            // irq data
  input wire logic       irq_n_oe_out          // irq enable
);
  logic [3:0] hw_age; // clocks since hw reset was low
  // saturating age tells a hw reload apart from a write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !hw_reset_n_in) hw_age <= 4'h0;
    else if (hw_age != 4'hf) hw_age <= hw_age + 4'h1;
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  property p_rst_dflt;
    $fell(rst_in) |-> expander_pins_out == 8'hff && spi_sdo_out == 1'b0 && !irq_n_oe_out;
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) else $error("reset outputs wrong");
  property p_rst_inputs;
    $fell(rst_in) |-> (expander_pins_oe_out == 8'h00)[*4];
  endproperty
  a_rst_inputs: assert property (p_rst_inputs) else $error("pin driven after reset");
  property p_hw_reset;
    (!hw_reset_n_in)[*4] |-> ##[1:8] expander_pins_oe_out == 8'h00;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("hw reset left pin driven");
  property p_pull_inputs;
    (expander_pins_oe_out & pullup_en_out) == 8'h00;
  endproperty
  a_pull_inputs: assert property (p_pull_inputs) else $error("pull-up on driven pin");
  property p_irq_low;
    irq_n_out == 1'b0;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq data not low");
  property p_sdo_sel;
    (!spi_cs_n_in)[*4] |-> spi_sdo_oe_out;
  endproperty
  a_sdo_sel: assert property (p_sdo_sel) else $error("sdo not driven when selected");
  property p_sdo_desel;
    spi_cs_n_in[*4] |-> !spi_sdo_oe_out;
  endproperty
  a_sdo_desel: assert property (p_sdo_desel) else $error("sdo driven when idle");
  property p_sdo_hold;
    $rose(spi_sclk_in) && !spi_cs_n_in |-> ($stable(spi_sdo_out))[*3];
  endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved around a clock rise");
  property p_out_by_frame;
    $changed(expander_pins_out) |-> hw_age < 4'ha || !$past(spi_cs_n_in, 3);
  endproperty
  a_out_by_frame: assert property (p_out_by_frame) else $error("output level moved idle");
endmodule // gex_top_props
bind gex_top gex_top_props #(.FILT_CYC(FILT_CYC)) u_props (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .hw_reset_n_in(hw_reset_n_in),
  .spi_sclk_in(spi_sclk_in), .spi_cs_n_in(spi_cs_n_in), .spi_sdi_in(spi_sdi_in),
  .spi_sdo_out(spi_sdo_out), .spi_sdo_oe_out(spi_sdo_oe_out), .expander_pins_in(expander_pins_in),
  .expander_pins_out(expander_pins_out), .expander_pins_oe_out(expander_pins_oe_out),
  .pullup_en_out(pullup_en_out), .irq_n_out(irq_n_out), .irq_n_oe_out(irq_n_oe_out));

// *** gex_spi_master.sv ***
// Purpose: behavioural spi master for the expander link
// Assumes: mode 0, link half period of four clocks
// Notes: sdi shows the inverse of its last bit between frames
`timescale 1ns/100ps
module gex_spi_master (
  input  wire logic clk_in,   // system clock
  input  wire logic sdo_in,   // data from device
  output logic      sclk_out, // link clock
  output logic      cs_n_out, // select, active low
  output logic      sdi_out   // data to device
);
  // idle link
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // one frame: command byte then data byte, msb first
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    @(posedge clk_in) cs_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 15; i >= 0; i--) begin
      sdi_out <= tx[i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      rx = {rx[6:0], sdo_in};
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    sdi_out <= ~sdi_out;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // gex_spi_master

// *** gex_top_bench.sv ***
// Purpose: self-checking bench for the expander block
// Assumes: master model paces the link at 160 ns
// Notes: short filter length keeps the run brief
`timescale 1ns/100ps
module gex_top_bench;
  logic       clk = 1'b0;  // system clock
  logic       rst = 1'b1;  // sync reset
  logic       hw_n = 1'b1; // hardware reset pin
  logic [7:0] pins = 8'h00;
  logic [7:0] rv;
  logic       sclk, cs_n, sdi, sdo, sdo_oe, irq_oe;
  logic [7:0] p_out, p_oe, pull;
  int         errors = 0;
  int         num_checks = 0;
  // reset values by address
  logic [7:0] dflt [11] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
  always #10 clk = ~clk;
  // block and four-signal link master
  gex_top #(.FILT_CYC(2)) dut (
    .sys_clk_in(clk), .rst_in(rst), .hw_reset_n_in(hw_n), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_sdi_in(sdi), .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe),
    .expander_pins_in(pins), .expander_pins_out(p_out), .expander_pins_oe_out(p_oe),
    .pullup_en_out(pull), .irq_n_out(), .irq_n_oe_out(irq_oe));
  gex_spi_master m (.clk_in(clk), .sdo_in(sdo), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    m.xfer({1'b0, a, 1'b0, d}, rv);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    m.xfer({1'b1, a, 1'b0, 8'h00}, d);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_defaults();
    pins <= 8'h3c;
    for (int a = 1; a < 11; a++) begin
      rd(6'(a), rv);
      check(rv, dflt[a]);
    end
    rd(gex_pkg::A_LEVEL, rv);
    check(rv, 8'h3c);
    check(p_oe, 8'h00);
    $display("test defaults done");
  endtask
  task automatic t_access();
    logic [7:0] e;
    for (int a = 0; a < 12; a++) wr(6'(a), 8'h5a ^ 8'(a));
    m.xfer({1'b0, gex_pkg::A_PULL, 1'b1, 8'h77}, rv);
    for (int a = 1; a < 12; a++) begin
      rd(6'(a), rv);
      e = (a == 7 || a == 11) ? 8'h00 : (a == 4) ? 8'h77 : 8'h5a ^ 8'(a);
      check(rv, e);
    end
    rd(6'h3f, rv);
    check(rv, 8'h00);
    $display("test access done");
  endtask
  task automatic t_hw();
    wr(gex_pkg::A_DIR, 8'h00);
    check(p_oe, 8'ha3);
    @(posedge clk) hw_n <= 1'b0;
    repeat (6) @(posedge clk);
    hw_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(p_oe, 8'h00);
    rd(gex_pkg::A_OUT, rv);
    check(rv, 8'hff);
    $display("test hw reset done");
  endtask
  task automatic t_pins();
    wr(gex_pkg::A_DIR, 8'h0f);
    wr(gex_pkg::A_OUT, 8'h5a);
    wr(gex_pkg::A_HIZ, 8'h40);
    wr(gex_pkg::A_POL, 8'h03);
    wr(gex_pkg::A_PULL, 8'hff);
    check(p_oe, 8'hb0);
    check(p_out, 8'h5a);
    check(pull, 8'h0f);
    rd(gex_pkg::A_LEVEL, rv);
    check(rv, 8'h5f);
    $display("test pins done");
  endtask
  task automatic t_irq();
    wr(gex_pkg::A_DIR, 8'hff);
    wr(gex_pkg::A_IEN, 8'h01);
    rd(gex_pkg::A_LEVEL, rv);
    @(posedge clk) pins <= 8'h3d;
    repeat (12) @(posedge clk);
    check({7'h00, irq_oe}, 8'h01);
    rd(gex_pkg::A_IPEND, rv);
    check(rv, 8'h01);
    rd(gex_pkg::A_LEVEL, rv);
    check(rv, 8'h3e);
    check({7'h00, irq_oe}, 8'h00);
    $display("test interrupt done");
  endtask
  task automatic t_edge();
    wr(gex_pkg::A_RISE, 8'h01);
    @(posedge clk) pins <= 8'h3c;
    repeat (12) @(posedge clk);
    check({7'h00, irq_oe}, 8'h00);
    @(posedge clk) pins <= 8'h3d;
    repeat (12) @(posedge clk);
    check({7'h00, irq_oe}, 8'h01);
    rd(gex_pkg::A_LEVEL, rv);
    check({7'h00, irq_oe}, 8'h00);
    $display("test edge done");
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_defaults();
    t_access();
    t_hw();
    t_pins();
    t_irq();
    t_edge();
    conclude();
  end
  // watchdog: some 50 frames of about 140 clocks each
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    conclude();
  end
endmodule // gex_top_bench
